// ### src/scp_device.sv
// serial control port, device end: instruction decode, write buffer, active registers
`include "scp_map.svh"
`default_nettype none
// Notes on behaviour
// - instruction bit 7 high reads, low writes
// - instruction bits 6 and 5 are ignored
// - low five instruction bits address the register
// - chip select high floats both data outputs
// - deselect mid-cycle holds position, then resumes
// - host owning the clock may tie select low
// - writes on two-way pin; config bit selects input-only
// - two-way mode keeps separate output floating
// - abort high ends cycle; next byte is instruction
// - abort resets sequencing only, never registers
// - update rising edge copies buffer to active
// - internal-update bit makes strobe pin an output
// - written bits act only after an update
// - config bit zero selects lsb-first for everything
// - highest numbered register bit is its msb
// - every bit captured on rising serial clock
// - reads return active values, driven on falling edge
// - after a cycle, eight edges form an instruction
// - abort keeps whole bytes, drops partial byte
module scp_device #(
  parameter int NREG       = 2,    // implemented registers
  parameter int UPD_PERIOD = 1024, // internal update interval, cycles
  parameter int UPD_WIDTH  = 8     // internal update pulse width, cycles
) (
  input  wire logic        clk_sys,     // system clock
  input  wire logic        rst_b,       // async reset, active low
  input  wire logic        ce,          // clock enable
  scp_if.device            port,        // serial pins
  output logic      [31:0] fconf_one_q, // active function config one
  output logic      [31:0] fconf_two_q  // active function config two
);
  localparam int AW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int UW = $clog2(UPD_PERIOD) + 1;

  // msb-first shifts toward bit 7, lsb-first toward bit 0
  function automatic logic [7:0] scp_shift(input logic [7:0] sr, input logic b,
                                           input logic lsb);
    scp_shift = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  // reset value of register i
  function automatic logic [31:0] scp_rst_val(input int i);
    if (i == int'(`SCP_ADDR_FCONF_ONE)) begin
      scp_rst_val = `SCP_RST_FCONF_ONE;
    end else if (i == int'(`SCP_ADDR_FCONF_TWO)) begin
      scp_rst_val = `SCP_RST_FCONF_TWO;
    end else begin
      scp_rst_val = 32'h0000_0000;
    end
  endfunction

  scp_pkg::scp_phase_type phase_q;
  logic [4:0]             cnt_q;
  logic [7:0]             sr_q;
  logic [4:0]             addr_q;
  logic [31:0]            buf_q [NREG];
  logic [31:0]            act_q [NREG];
  logic                   dout_q;
  logic                   rd_act_q;
  logic                   sdio_oe_q;
  logic                   sdo_oe_q;
  logic [UW-1:0]          upd_cnt_q;
  logic                   upd_o_q;
  logic                   upd_oe_q;
  logic [4:0]             pin_raw;
  logic [4:0]             pin_lvl;
  logic [4:0]             pin_rise;
  logic [4:0]             pin_fall;

  // every pin from the host crosses two flops before use
  assign pin_raw = {port.sclk, port.cs_b, port.sdio, port.io_reset, port.io_update};
  scp_sync #(
    .W   (5),
    .RST (5'h0c)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .din     (pin_raw),
    .lvl     (pin_lvl),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // pin qualification; clock edges seen while deselected are ignored
  wire logic sel      = ~pin_lvl[3];
  wire logic bit_in   = pin_lvl[2];
  wire logic abort    = pin_lvl[1];
  wire logic sck_rise = pin_rise[4] & sel & ~abort;
  wire logic sck_fall = pin_fall[4] & sel & ~abort;

  // mode bits come from the active copies, so they change only on update
  wire logic lsb_first = act_q[0][`SCP_BIT_LSB_FIRST];
  wire logic in_only   = act_q[0][`SCP_BIT_INPUT_ONLY];
  wire logic int_upd   = act_q[1][`SCP_BIT_INT_UPDATE];

  // bit assembly and position decode
  wire logic [7:0] sr_next    = scp_shift(sr_q, bit_in, lsb_first);
  wire logic       in_instr   = (phase_q == scp_pkg::SCP_PH_INSTR);
  wire logic       in_write   = (phase_q == scp_pkg::SCP_PH_WRITE);
  wire logic       in_read    = (phase_q == scp_pkg::SCP_PH_READ);
  wire logic       byte_done  = sck_rise & (cnt_q[2:0] == 3'h7);
  wire logic       last_bit   = (cnt_q == 5'h1f);
  wire logic       cyc_done   = sck_rise & ~in_instr & last_bit;
  wire logic [1:0] lane       = lsb_first ? cnt_q[4:3] : ~cnt_q[4:3];
  wire logic [4:0] rd_pos     = lsb_first ? cnt_q : ~cnt_q;
  wire logic       addr_ok    = (int'(addr_q) < NREG);
  wire logic [AW-1:0] reg_sel = addr_q[AW-1:0];
  wire logic       buf_wr     = byte_done & in_write & addr_ok;
  wire logic [31:0] rd_word   = addr_ok ? act_q[reg_sel] : 32'h0000_0000;

  // update source: pin edge in input mode, own timer in output mode
  wire logic upd_ext  = pin_rise[0] & ~int_upd;
  wire logic upd_int  = int_upd & (upd_cnt_q == '0);
  wire logic do_upd   = upd_ext | upd_int;

  // read drive window opens on the first falling edge of the data phase
  wire logic rd_act_d = in_read & ~cyc_done & ~abort & (rd_act_q | sck_fall);

  // phase, bit counter, shift register and address
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= scp_pkg::SCP_PH_INSTR;
      cnt_q   <= 5'h00;
      sr_q    <= 8'h00;
      addr_q  <= 5'h00;
    end else if (ce) begin
      if (abort) begin
        phase_q <= scp_pkg::SCP_PH_INSTR;
        cnt_q   <= 5'h00;
        sr_q    <= 8'h00;
      end else if (sck_rise) begin
        sr_q  <= sr_next;
        cnt_q <= cnt_q + 5'h01;
        unique case (phase_q)
          scp_pkg::SCP_PH_INSTR: begin
            if (cnt_q == 5'h07) begin
              // bits 6 and 5 are never looked at
              phase_q <= sr_next[`SCP_INSTR_DIR_BIT] ? scp_pkg::SCP_PH_READ
                                                     : scp_pkg::SCP_PH_WRITE;
              addr_q  <= sr_next[`SCP_INSTR_ADDR_MSB:0];
              cnt_q   <= 5'h00;
            end
          end
          scp_pkg::SCP_PH_WRITE, scp_pkg::SCP_PH_READ: begin
            if (last_bit) begin
              phase_q <= scp_pkg::SCP_PH_INSTR;
            end
          end
        endcase
      end
    end
  end

  // write buffer and active copy per register; abort never touches them
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        buf_q[i] <= scp_rst_val(i);
        act_q[i] <= scp_rst_val(i);
      end else if (ce) begin
        if (buf_wr && (reg_sel == AW'(i))) begin
          buf_q[i][lane*8 +: 8] <= sr_next;
        end
        if (do_upd) begin
          act_q[i] <= buf_q[i];
        end
      end
    end
  end

  // read data and output enables; select high floats both outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dout_q    <= 1'b0;
      rd_act_q  <= 1'b0;
      sdio_oe_q <= 1'b0;
      sdo_oe_q  <= 1'b0;
    end else if (ce) begin
      if (sck_fall && in_read) begin
        dout_q <= rd_word[rd_pos];
      end
      rd_act_q  <= rd_act_d;
      sdio_oe_q <= sel & rd_act_d & ~in_only;
      sdo_oe_q  <= sel & rd_act_d & in_only;
    end
  end

  // internal update timer; drives the strobe pin only in output mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upd_cnt_q <= '0;
      upd_o_q   <= 1'b0;
      upd_oe_q  <= 1'b0;
    end else if (ce) begin
      // take the pin only after one own pulse, so a host strobe that set the mode has ended
      upd_oe_q <= int_upd & (upd_oe_q | (upd_cnt_q == UW'(UPD_WIDTH)));
      upd_o_q  <= int_upd & (upd_cnt_q < UW'(UPD_WIDTH));
      if (!int_upd || (upd_cnt_q == UW'(UPD_PERIOD - 1))) begin
        upd_cnt_q <= '0;
      end else begin
        upd_cnt_q <= upd_cnt_q + 1'b1;
      end
    end
  end

  // pins and user outputs straight from flops
  assign port.dev_sdio_o  = dout_q;
  assign port.dev_sdio_oe = sdio_oe_q;
  assign port.dev_sdo_o   = dout_q;
  assign port.dev_sdo_oe  = sdo_oe_q;
  assign port.dev_upd_o   = upd_o_q;
  assign port.dev_upd_oe  = upd_oe_q;
  assign fconf_one_q      = act_q[0];
  assign fconf_two_q      = act_q[1];
endmodule
`default_nettype wire

// ### src/scp_map.svh
// offsets, field positions, reset values and timing counts of the serial control port
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
// device register addresses and reset values
`define SCP_ADDR_FCONF_ONE 5'h00
`define SCP_ADDR_FCONF_TWO 5'h01
`define SCP_RST_FCONF_ONE 32'h0000_0000
`define SCP_RST_FCONF_TWO 32'h0040_0800
// device field positions
`define SCP_BIT_LSB_FIRST 0
`define SCP_BIT_INPUT_ONLY 1
`define SCP_BIT_INT_UPDATE 23
`define SCP_INSTR_DIR_BIT 7
`define SCP_INSTR_ADDR_MSB 4
// frame shape
`define SCP_INSTR_BITS 8
`define SCP_REG_BITS 32
`define SCP_FRAME_BITS 40
// timing: system clock, serial clock half period, sync clock period
`define SCP_CLK_NS 4
`define SCP_SCLK_HALF_NS 64
`define SCP_SCLK_HALF_CYC (`SCP_SCLK_HALF_NS / `SCP_CLK_NS)
`define SCP_SYNC_CLK_NS 16
`define SCP_UPD_MIN_CYC (`SCP_SYNC_CLK_NS / `SCP_CLK_NS + 1)
// host controller registers (word index)
`define SCP_H_CTRL 4'h0
`define SCP_H_CFG 4'h1
`define SCP_H_WDATA 4'h2
`define SCP_H_RDATA 4'h3
`define SCP_H_STAT 4'h4
// host control fields
`define SCP_H_GO 0
`define SCP_H_DIR 1
`define SCP_H_UPD 2
`define SCP_H_ABORT 3
`define SCP_H_ADDR_LSB 8
`define SCP_H_ADDR_MSB 12
`define SCP_H_CFG_LSB 0
`define SCP_H_CFG_INONLY 1
`endif

// ### src/scp_pkg.sv
// types shared by both ends of the serial control port
`default_nettype none
package scp_pkg;
  // device transfer phase
  typedef enum logic [1:0] {
    SCP_PH_INSTR = 2'b00,
    SCP_PH_WRITE = 2'b01,
    SCP_PH_READ  = 2'b10
  } scp_phase_type;
  // host controller state
  typedef enum logic [1:0] {
    SCP_H_IDLE   = 2'b00,
    SCP_H_SHIFT  = 2'b01,
    SCP_H_STROBE = 2'b10
  } scp_hstate_type;
endpackage
`default_nettype wire

// ### src/scp_if.sv
// serial control port pins between host and device, with two-way pins resolved
`default_nettype none
interface scp_if;
  logic sclk;         // serial clock, host drives
  logic cs_b;         // chip select, active low
  logic io_reset;     // abort, active high
  logic host_sdio_o;  // host data onto two-way pin
  logic host_sdio_oe; // host drives two-way pin
  logic dev_sdio_o;   // device data onto two-way pin
  logic dev_sdio_oe;  // device drives two-way pin
  logic dev_sdo_o;    // device separate output
  logic dev_sdo_oe;   // device drives separate output
  logic host_upd_o;   // host update strobe
  logic host_upd_oe;  // host drives update strobe
  logic dev_upd_o;    // device update strobe
  logic dev_upd_oe;   // device drives update strobe
  logic sdio;         // resolved two-way data line
  logic serial_data_out;          // resolved separate output line
  logic io_update;    // resolved update strobe line
  // an undriven data line floats to its pull-up, the strobe to its pull-down
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  assign serial_data_out = dev_sdo_oe ? dev_sdo_o : 1'b1;
  assign io_update = host_upd_oe ? host_upd_o : (dev_upd_oe ? dev_upd_o : 1'b0);
  modport device (input sclk, cs_b, io_reset, sdio, io_update,
                  output dev_sdio_o, dev_sdio_oe, dev_sdo_o, dev_sdo_oe,
                  dev_upd_o, dev_upd_oe);
  modport host (input sdio, serial_data_out, io_update,
                output sclk, cs_b, io_reset, host_sdio_o, host_sdio_oe,
                host_upd_o, host_upd_oe);
endinterface
`default_nettype wire

// ### src/scp_sync.sv
// two-flop synchroniser with edge pulses for pins from outside the clock domain
`default_nettype none
module scp_sync #(
  parameter int           W   = 1,  // number of pins
  parameter logic [W-1:0] RST = '0  // level assumed during reset
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         rst_b,   // async reset, active low
  input  wire logic         ce,      // clock enable
  input  wire logic [W-1:0] din,     // raw pins
  output logic      [W-1:0] lvl,     // synchronised level
  output logic      [W-1:0] rise,    // one-cycle rising pulse
  output logic      [W-1:0] fall     // one-cycle falling pulse
);
  logic [W-1:0] meta_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] last_q;
  // meta_q is read by lvl_q alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST;
      lvl_q  <= RST;
      last_q <= RST;
    end else if (ce) begin
      meta_q <= din;
      lvl_q  <= meta_q;
      last_q <= lvl_q;
    end
  end
  // edges from the settled stages only
  assign lvl  = lvl_q;
  assign rise = lvl_q & ~last_q;
  assign fall = ~lvl_q & last_q;
endmodule
`default_nettype wire

// ### src/scp_host.sv
// serial control port, host end: register-driven controller that makes the serial clock
`include "scp_map.svh"
`default_nettype none
module scp_host #(
  parameter int SCLK_HALF  = `SCP_SCLK_HALF_CYC, // serial clock half period, cycles
  parameter int STROBE_CYC = `SCP_UPD_MIN_CYC    // update and abort pulse width, cycles
) (
  input  wire logic        clk_sys,     // system clock
  input  wire logic        rst_b,       // async reset, active low
  input  wire logic        ce,          // clock enable
  input  wire logic [3:0]  bus_addr,    // register index
  input  wire logic [31:0] bus_wdata,   // write data
  input  wire logic        bus_wr,      // write strobe
  input  wire logic        bus_rd,      // read strobe
  output logic      [31:0] bus_rdata_q, // read data, cycle after strobe
  scp_if.host              port         // serial pins
);
  localparam int TW = $clog2(SCLK_HALF + STROBE_CYC) + 1;

  scp_pkg::scp_hstate_type state_q;
  logic [TW-1:0]           tim_q;
  logic [5:0]              bitn_q;
  logic [39:0]             tx_q;
  logic [31:0]             rx_q;
  logic [31:0]             wdata_q;
  logic                    rw_q;
  logic                    lsb_q;
  logic                    in_only_q;
  logic                    sclk_q;
  logic                    cs_b_q;
  logic                    sdio_o_q;
  logic                    sdio_oe_q;
  logic                    upd_q;
  logic                    abort_q;
  logic [1:0]              rx_lvl;

  // returning data lines cross two flops
  scp_sync #(
    .W   (2),
    .RST (2'h3)
  ) u_rx_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .din     ({port.serial_data_out, port.sdio}),
    .lvl     (rx_lvl),
    .rise    (),
    .fall    ()
  );

  // register decode
  wire logic       idle    = (state_q == scp_pkg::SCP_H_IDLE);
  wire logic       ctrl_wr = bus_wr & (bus_addr == `SCP_H_CTRL);
  wire logic       go      = ctrl_wr & bus_wdata[`SCP_H_GO] & idle;
  wire logic       upd     = ctrl_wr & bus_wdata[`SCP_H_UPD] & idle;
  wire logic       abt     = ctrl_wr & bus_wdata[`SCP_H_ABORT];
  wire logic [7:0] instr   = {bus_wdata[`SCP_H_DIR], 2'b00,
                              bus_wdata[`SCP_H_ADDR_MSB:`SCP_H_ADDR_LSB]};
  wire logic       tick    = (tim_q == TW'(SCLK_HALF - 1));
  wire logic       rx_bit  = in_only_q ? rx_lvl[1] : rx_lvl[0];
  wire logic       in_data = (bitn_q >= 6'h08);
  wire logic [31:0] rd_mux =
    (bus_addr == `SCP_H_CFG)   ? {30'h0, in_only_q, lsb_q} :
    (bus_addr == `SCP_H_WDATA) ? wdata_q :
    (bus_addr == `SCP_H_RDATA) ? rx_q :
    (bus_addr == `SCP_H_STAT)  ? {31'h0, ~idle} : 32'h0000_0000;

  // register file and read port
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata_q <= 32'h0000_0000;
      wdata_q     <= 32'h0000_0000;
      lsb_q       <= 1'b0;
      in_only_q   <= 1'b0;
    end else if (ce) begin
      bus_rdata_q <= bus_rd ? rd_mux : 32'h0000_0000;
      if (bus_wr && (bus_addr == `SCP_H_WDATA)) begin
        wdata_q <= bus_wdata;
      end
      if (bus_wr && (bus_addr == `SCP_H_CFG)) begin
        lsb_q     <= bus_wdata[`SCP_H_CFG_LSB];
        in_only_q <= bus_wdata[`SCP_H_CFG_INONLY];
      end
    end
  end

  // frame sequencer: data changes on falling, device samples on rising
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= scp_pkg::SCP_H_IDLE;
      tim_q     <= '0;
      bitn_q    <= 6'h00;
      tx_q      <= 40'h00_0000_0000;
      rx_q      <= 32'h0000_0000;
      rw_q      <= 1'b0;
      sclk_q    <= 1'b0;
      cs_b_q    <= 1'b1;
      sdio_o_q  <= 1'b0;
      sdio_oe_q <= 1'b0;
      upd_q     <= 1'b0;
      abort_q   <= 1'b0;
    end else if (ce) begin
      sdio_o_q  <= lsb_q ? tx_q[0] : tx_q[39];
      sdio_oe_q <= (state_q == scp_pkg::SCP_H_SHIFT) & ~(rw_q & in_data);
      tim_q     <= tim_q + 1'b1;
      unique case (state_q)
        scp_pkg::SCP_H_IDLE: begin
          tim_q <= '0;
          if (abt) begin
            state_q <= scp_pkg::SCP_H_STROBE;
            abort_q <= 1'b1;
          end else if (go) begin
            state_q <= scp_pkg::SCP_H_SHIFT;
            cs_b_q  <= 1'b0;
            bitn_q  <= 6'h00;
            rw_q    <= bus_wdata[`SCP_H_DIR];
            tx_q    <= lsb_q ? {wdata_q, instr} : {instr, wdata_q};
          end else if (upd) begin
            state_q <= scp_pkg::SCP_H_STROBE;
            upd_q   <= 1'b1;
          end
        end
        scp_pkg::SCP_H_SHIFT: begin
          if (abt) begin
            state_q <= scp_pkg::SCP_H_STROBE;
            abort_q <= 1'b1;
            cs_b_q  <= 1'b1;
            sclk_q  <= 1'b0;
            tim_q   <= '0;
          end else if (tick) begin
            tim_q  <= '0;
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              if (rw_q && in_data) begin
                rx_q <= lsb_q ? {rx_bit, rx_q[31:1]} : {rx_q[30:0], rx_bit};
              end
            end else begin
              tx_q   <= lsb_q ? {1'b0, tx_q[39:1]} : {tx_q[38:0], 1'b0};
              bitn_q <= bitn_q + 6'h01;
              if (bitn_q == 6'(`SCP_FRAME_BITS - 1)) begin
                state_q <= scp_pkg::SCP_H_IDLE;
                cs_b_q  <= 1'b1;
              end
            end
          end
        end
        scp_pkg::SCP_H_STROBE: begin
          if (tim_q == TW'(STROBE_CYC - 1)) begin
            state_q <= scp_pkg::SCP_H_IDLE;
            upd_q   <= 1'b0;
            abort_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // pins straight from flops
  assign port.sclk         = sclk_q;
  assign port.cs_b         = cs_b_q;
  assign port.io_reset     = abort_q;
  assign port.host_sdio_o  = sdio_o_q;
  assign port.host_sdio_oe = sdio_oe_q;
  assign port.host_upd_o   = upd_q;
  assign port.host_upd_oe  = upd_q;
endmodule
`default_nettype wire

// ### tb/scp_chk.sv
// assertions on the serial pins between host and device ends
`default_nettype none
module scp_chk (
  input wire logic clk_sys,      // system clock
  input wire logic rst_b,        // async reset, active low
  input wire logic sclk,         // serial clock
  input wire logic cs_b,         // chip select, active low
  input wire logic io_reset,     // abort
  input wire logic host_sdio_oe, // host drives data line
  input wire logic dev_sdio_o,   // device data
  input wire logic dev_sdio_oe,  // device drives data line
  input wire logic dev_sdo_oe,   // device drives separate output
  input wire logic host_upd_oe,  // host drives strobe
  input wire logic dev_upd_oe,   // device drives strobe
  input wire logic io_update     // resolved strobe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic       sclk_q;
  logic [5:0] rise_cnt_q;
  // serial clock rises per frame, cleared while deselected
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      rise_cnt_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_b) begin
        rise_cnt_q <= 6'h00;
      end else if (sclk && !sclk_q) begin
        rise_cnt_q <= rise_cnt_q + 6'h01;
      end
    end
  end
  sequence s_deselected;
    cs_b [*6];
  endsequence
  sequence s_upd_hold;
    io_update [*5];
  endsequence
  // sync clock is 4 cycles, so a strobe must stand 5
  a_upd_width: assert property ($rose(io_update) |-> s_upd_hold)
    else $error("update strobe too short");
  a_upd_owner: assert property (!(host_upd_oe && dev_upd_oe))
    else $error("update strobe driven by both ends");
  a_desel_float: assert property (s_deselected |-> !dev_sdio_oe && !dev_sdo_oe)
    else $error("device drives while deselected");
  a_one_read_pin: assert property (!(dev_sdio_oe && dev_sdo_oe))
    else $error("both device outputs driven");
  a_no_clash: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("data line driven by both ends");
  a_abort_quiet: assert property ($rose(io_reset) |-> ##[1:8] !(dev_sdio_oe || dev_sdo_oe))
    else $error("device still drives after abort");
  a_oe_start: assert property ($rose(dev_sdio_oe) || $rose(dev_sdo_oe) |-> !sclk && !cs_b)
    else $error("read drive began outside a low clock phase");
  a_read_steady: assert property (dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_o)
    |-> !sclk)
    else $error("read bit changed while clock high");
  a_frame_bits: assert property ($rose(cs_b) |-> (rise_cnt_q == 6'd40) or (##[0:2] io_reset))
    else $error("frame ended with wrong bit count");
  a_bits_bound: assert property (rise_cnt_q <= 6'd40)
    else $error("frame ran past forty bits");
endmodule
`default_nettype wire

// ### tb/serial_control_port_test.sv
// self-checking test of host and device ends joined over the serial pins
`include "scp_map.svh"
`default_nettype none
module serial_control_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata_q;
  logic [31:0] fconf_one_q;
  logic [31:0] fconf_two_q;
  logic        sdo_seen = 1'b0;
  logic        sdo_clr = 1'b0;
  logic        sclk_q = 1'b0;
  logic [39:0] frame_q = 40'h0;
  int          n_errors = 0;
  int          num_checks = 0;
  scp_if u_scp_if ();
  scp_host u_scp_host (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
    .port(u_scp_if));
  scp_device u_scp_device (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .port(u_scp_if),
    .fconf_one_q(fconf_one_q), .fconf_two_q(fconf_two_q));
  scp_chk u_scp_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(u_scp_if.sclk),
    .cs_b(u_scp_if.cs_b), .io_reset(u_scp_if.io_reset), .host_sdio_oe(u_scp_if.host_sdio_oe),
    .dev_sdio_o(u_scp_if.dev_sdio_o), .dev_sdio_oe(u_scp_if.dev_sdio_oe),
    .dev_sdo_oe(u_scp_if.dev_sdo_oe), .host_upd_oe(u_scp_if.host_upd_oe),
    .dev_upd_oe(u_scp_if.dev_upd_oe), .io_update(u_scp_if.io_update));
  always #2 clk_sys = ~clk_sys;
  // wire snoop in the system clock, so no race with the host's own edges
  always @(posedge clk_sys) begin
    sclk_q <= u_scp_if.sclk;
    if (u_scp_if.sclk && !sclk_q && !u_scp_if.cs_b) frame_q <= {frame_q[38:0], u_scp_if.sdio};
    if (sdo_clr) sdo_seen <= 1'b0;
    else if (u_scp_if.dev_sdo_oe === 1'b1) sdo_seen <= 1'b1;
  end
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic bus_w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic bus_r(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_q;
  endtask
  // polling bound covers a full 40-bit frame with margin
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) bus_r(`SCP_H_STAT, s);
    chk("busy", 40'h0, {39'h0, s[0]});
  endtask
  task automatic go(input logic [4:0] a, input logic rd, input logic [31:0] d);
    wait_idle();
    bus_w(`SCP_H_WDATA, d);
    bus_w(`SCP_H_CTRL, {19'h0, a, 6'h0, rd, 1'b1});
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    go(a, 1'b0, d);
    wait_idle();
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] v;
    go(a, 1'b1, 32'h0);
    wait_idle();
    bus_r(`SCP_H_RDATA, v);
    chk("read data", {8'h0, e}, {8'h0, v});
  endtask
  task automatic update(input logic [31:0] e1, input logic [31:0] e2);
    bus_w(`SCP_H_CTRL, 32'h4);
    for (int i = 0; i < 40 && (fconf_one_q !== e1 || fconf_two_q !== e2); i++) @(posedge clk_sys);
    chk("fconf_one", {8'h0, e1}, {8'h0, fconf_one_q});
    chk("fconf_two", {8'h0, e2}, {8'h0, fconf_two_q});
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk("reset one", {8'h0, `SCP_RST_FCONF_ONE}, {8'h0, fconf_one_q});
    chk("reset two", {8'h0, `SCP_RST_FCONF_TWO}, {8'h0, fconf_two_q});
    bus_r(4'h9, v);
    chk("unmapped host read", 40'h0, {8'h0, v});
    $display("test reset done");
  endtask
  task automatic t_write_update();
    wr_reg(5'h01, 32'h1234_5601);
    chk("write frame", {8'h01, 32'h1234_5601}, frame_q);
    chk("before update", {8'h0, `SCP_RST_FCONF_TWO}, {8'h0, fconf_two_q});
    update(32'h0, 32'h1234_5601);
    rd_reg(5'h01, 32'h1234_5601);
    chk("read frame", {8'h81, 32'h1234_5601}, frame_q);
    $display("test write and update done");
  endtask
  task automatic t_abort();
    go(5'h01, 1'b0, 32'h9abc_def0);
    repeat (20) @(posedge u_scp_if.sclk);
    bus_w(`SCP_H_CTRL, 32'h8);
    wait_idle();
    update(32'h0, 32'h9a34_5601);
    rd_reg(5'h01, 32'h9a34_5601);
    $display("test abort done");
  endtask
  task automatic t_unmapped();
    wr_reg(5'h05, 32'hffff_ffff);
    rd_reg(5'h05, 32'h0);
    update(32'h0, 32'h9a34_5601);
    $display("test unmapped done");
  endtask
  task automatic t_modes();
    wr_reg(5'h00, 32'h1);
    update(32'h1, 32'h9a34_5601);
    bus_w(`SCP_H_CFG, 32'h1);
    wr_reg(5'h01, 32'h0f1e_2d3c);
    // instruction and data bit-reversed, as the snoop shifts first bit to the top
    chk("lsb frame", 40'h80_3cb4_78f0, frame_q);
    update(32'h1, 32'h0f1e_2d3c);
    @(posedge clk_sys);
    sdo_clr <= 1'b1;
    @(posedge clk_sys);
    sdo_clr <= 1'b0;
    rd_reg(5'h01, 32'h0f1e_2d3c);
    chk("sdo in two-way", 40'h0, {39'h0, sdo_seen});
    wr_reg(5'h00, 32'h3);
    update(32'h3, 32'h0f1e_2d3c);
    bus_w(`SCP_H_CFG, 32'h3);
    rd_reg(5'h00, 32'h3);
    chk("sdo in input-only", 40'h1, {39'h0, sdo_seen});
    $display("test modes done");
  endtask
  // device takes the strobe pin and copies buffers on its own timer
  task automatic t_internal();
    wr_reg(5'h01, 32'h0080_0000);
    update(32'h3, 32'h0080_0000);
    wr_reg(5'h00, 32'h1);
    for (int i = 0; i < 1100 && fconf_one_q !== 32'h1; i++) @(posedge clk_sys);
    chk("timed update", 40'h1, {8'h0, fconf_one_q});
    chk("strobe owner", 40'h1, {39'h0, u_scp_if.dev_upd_oe});
    $display("test internal update done");
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: over three times the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    $display("unexpected watchdog: expected finish, seen hang");
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_write_update();
    t_abort();
    t_unmapped();
    t_modes();
    t_internal();
    close_out();
  end
endmodule
`default_nettype wire
